//--- nim_alu.sv
// Four-bit adder with subtract by complement, carry out doubles as no-borrow
`timescale 1ns/1ps
module nim_alu (
  input  wire logic [3:0] a,
  input  wire logic [3:0] b,
  input  wire logic       sub,
  output logic      [3:0] res,
  output logic            cy
);

  logic [3:0] b_eff;
  logic [4:0] sum;

  // Subtraction is a plus inverted b plus one, so cy high means no borrow
  always_comb
  begin
    b_eff = sub ? ~b : b;
    sum   = {1'b0, a} + {1'b0, b_eff} + {4'h0, sub};
    res   = sum[3:0];
    cy    = sum[4];
  end

endmodule

//--- nim_core.sv
// Instruction decode and execute for the nibble core, with output latches and carrier
`timescale 1ns/1ps
`include "nim_params.svh"
// Functional notes
// RULE1 - Forty-three one-byte instructions, each split into opcode and operand.
// RULE2 - Unconditional class always sets the status flag.
// RULE3 - Add, increment memory and increment Y set the flag only on carry.
// RULE4 - Subtract and decrement instructions set the flag only without borrow.
// RULE5 - Bit test and less-or-equal compares set the flag when true.
// RULE6 - Not-equal compares set the flag only when operands differ.
// RULE7 - Negate sets the flag only when the result is zero.
// RULE8 - Copy Y into accumulator, Y unchanged.
// RULE9 - Copy accumulator into Y.
// RULE10 - Clear accumulator to zero unconditionally.
// RULE11 - Store accumulator to RAM at X page and Y address.
// RULE12 - Conditional jump loads page buffer and address only when flag is one.
// RULE13 - Conditional call saves return point and jumps only when flag is one.
// RULE14 - Watchdog clear restarts the watchdog counter from zero.
// RULE15 - Set and reset output pick their target from Y and X.
// RULE16 - X 0 or 1, Y 0 to 7: drive output D(Y) high or low.
// RULE17 - Y 8: start carrier toggling, fixed high in mode 5; reset stops low.
// RULE18 - Y 9 or F: all D outputs high or low; F also sets R pins.
// RULE19 - Y A to D: drive pin R(Y-A) high or low.
// RULE20 - Y E: drive all four R pins high or low.
// RULE21 - X 2 or 3: Y 0 drives D8, Y 1 drives D9.
// RULE22 - Jump with flag zero advances sequentially and sets flag to one.
// RULE23 - Store-and-advance writes accumulator to RAM then increments Y.
// RULE24 - Arithmetic gives four-bit results and updates the flag by class.
// RULE25 - Input reads K or R, pulse-mode load takes Y, no-op only advances.
module nim_core (
  input  wire logic                     mclk,
  input  wire logic                     srst,
  input  wire logic [7:0]               rom_data,
  input  wire logic [3:0]               ram_rdata,
  input  wire logic [3:0]               k_pins,
  input  wire logic [3:0]               r_in,
  output logic      [9:0]               rom_addr,
  output nim_pkg::nim_ram_req_type      ram_req,
  output logic      [9:0]               d_level,
  output logic      [3:0]               r_out,
  output logic      [3:0]               r_oe,
  output logic                          carrier_pulse_pin,
  output logic                          watchdog_clear,
  output logic                          stop_req,
  output logic                          status_flag
);

  localparam nim_pkg::nim_core_type CORE_RST = '{
    ph:      nim_pkg::PH_FETCH,
    pmode:   `NIM_RST_PMODE,
    flag:    `NIM_RST_FLAG,
    r_lat:   `NIM_RST_R,
    default: '0
  };

  nim_pkg::nim_core_type cur_ff;
  nim_pkg::nim_core_type nxt_core;
  logic [3:0]            alu_a;
  logic [3:0]            alu_b;
  logic                  alu_sub;
  logic [3:0]            alu_res;
  logic                  alu_cy;
  logic [9:0]            seq_addr;
  logic                  out_val;

  // Program counter steps within its page
  function automatic logic [9:0] next_seq(input logic [9:0] cur_addr);
    next_seq = {cur_addr[9:6], cur_addr[5:0] + 6'h01};
  endfunction

  // Carrier period per mode; fixed modes return a dummy period
  function automatic logic [3:0] car_period(input logic [2:0] mode);
    unique case (mode)
      3'h0, 3'h1, 3'h6: car_period = `NIM_PER_12;
      3'h2, 3'h3:       car_period = `NIM_PER_8;
      3'h4:             car_period = `NIM_PER_11;
      default:          car_period = `NIM_PER_12;
    endcase
  endfunction

  // Carrier high time per mode
  function automatic logic [3:0] car_high(input logic [2:0] mode);
    unique case (mode)
      3'h0:       car_high = `NIM_HI_6;
      3'h1, 3'h2: car_high = `NIM_HI_4;
      3'h3:       car_high = `NIM_HI_2;
      3'h4:       car_high = `NIM_HI_4;
      3'h6:       car_high = `NIM_HI_3;
      default:    car_high = `NIM_HI_6;
    endcase
  endfunction

  // Mode 5 and the unused code 7 give a steady level instead of pulses
  function automatic logic car_fixed(input logic [2:0] mode);
    car_fixed = (mode == `NIM_MODE_FIXED) || (mode == 3'h7);
  endfunction

  nim_alu u_alu (
    .a   (alu_a),
    .b   (alu_b),
    .sub (alu_sub),
    .res (alu_res),
    .cy  (alu_cy)
  );

  assign seq_addr = next_seq({cur_ff.pa, cur_ff.pc});
  assign out_val  = (cur_ff.ir[4:0] == `NIM_OP_SETO);

  // Operand steering for the shared adder
  always_comb
  begin
    alu_a   = cur_ff.acc;
    alu_b   = ram_rdata;
    alu_sub = 1'b0;
    if (cur_ff.ir[7:4] == `NIM_F2_ALEI)
    begin
      alu_a   = cur_ff.ir[3:0];
      alu_b   = cur_ff.acc;
      alu_sub = 1'b1;
    end
    else if (cur_ff.ir[7:5] == 3'h0)
    begin
      unique case (cur_ff.ir[4:0])
        `NIM_OP_SUBM, `NIM_OP_ALEM:
        begin
          alu_a   = ram_rdata;
          alu_b   = cur_ff.acc;
          alu_sub = 1'b1;
        end
        `NIM_OP_INCM, `NIM_OP_DECM:
        begin
          alu_a   = ram_rdata;
          alu_b   = 4'h1;
          alu_sub = (cur_ff.ir[4:0] == `NIM_OP_DECM);
        end
        `NIM_OP_INCA, `NIM_OP_DECA:
        begin
          alu_b   = 4'h1;
          alu_sub = (cur_ff.ir[4:0] == `NIM_OP_DECA);
        end
        `NIM_OP_INCY, `NIM_OP_DECY:
        begin
          alu_a   = cur_ff.y;
          alu_b   = 4'h1;
          alu_sub = (cur_ff.ir[4:0] == `NIM_OP_DECY);
        end
        `NIM_OP_NEG:
        begin
          alu_a   = 4'h0;
          alu_b   = cur_ff.acc;
          alu_sub = 1'b1;
        end
        default:
        begin
          alu_a   = cur_ff.acc;
          alu_b   = ram_rdata;
          alu_sub = 1'b0;
        end
      endcase
    end
  end

  // Next state: three phases per instruction, carrier and pin syncs run every cycle
  always_comb
  begin
    nxt_core        = cur_ff;
    nxt_core.wdc    = 1'b0;
    nxt_core.halt   = 1'b0;
    nxt_core.ram.we = 1'b0;
    nxt_core.k_s1   = k_pins;
    nxt_core.k_s2   = cur_ff.k_s1;
    nxt_core.r_s1   = r_in;
    nxt_core.r_s2   = cur_ff.r_s1;
    // Carrier divider; a mode change mid-pulse takes effect on the next cycle, count kept
    if (cur_ff.car_run && !car_fixed(cur_ff.pmode))
    begin
      if (cur_ff.car_cnt >= car_period(cur_ff.pmode) - 4'h1)
        nxt_core.car_cnt = 4'h0;
      else
        nxt_core.car_cnt = cur_ff.car_cnt + 4'h1;
      nxt_core.car_pin = (cur_ff.car_cnt < car_high(cur_ff.pmode)); // RULE17
    end
    else
    begin
      nxt_core.car_pin = cur_ff.car_run; // RULE17
    end
    unique case (cur_ff.ph)
      nim_pkg::PH_FETCH:
      begin
        // RAM address is frozen for the whole instruction, so a write lands at old Y
        nxt_core.ram.addr = {cur_ff.x[0], cur_ff.y}; // RULE11
        nxt_core.ph       = nim_pkg::PH_DECODE;
      end
      nim_pkg::PH_DECODE:
      begin
        nxt_core.ir = rom_data; // RULE1
        nxt_core.ph = nim_pkg::PH_EXEC;
      end
      nim_pkg::PH_EXEC:
      begin
        nxt_core.ph   = nim_pkg::PH_FETCH;
        nxt_core.pc   = seq_addr[5:0]; // RULE25
        nxt_core.pa   = seq_addr[9:6];
        nxt_core.flag = 1'b1; // RULE2
        if (cur_ff.ir[7])
        begin
          // Jump and call share the taken path
          if (cur_ff.flag)
          begin
            nxt_core.pa = cur_ff.pb; // RULE12
            nxt_core.pc = cur_ff.ir[5:0]; // RULE12
            if (cur_ff.ir[6] == `NIM_F3_CALL)
            begin
              nxt_core.ret_pc = seq_addr[5:0]; // RULE13
              nxt_core.ret_pa = seq_addr[9:6]; // RULE13
            end
          end
          // Not taken: sequential step and flag forced to one above // RULE22
        end
        else if (cur_ff.ir[7:4] == `NIM_F1_NIB)
        begin
          unique case (cur_ff.ir[3:2])
            `NIM_F1_SETB:
            begin
              nxt_core.ram.we    = 1'b1;
              nxt_core.ram.wdata = ram_rdata | (4'h1 << cur_ff.ir[1:0]);
            end
            `NIM_F1_CLRB:
            begin
              nxt_core.ram.we    = 1'b1;
              nxt_core.ram.wdata = ram_rdata & ~(4'h1 << cur_ff.ir[1:0]);
            end
            `NIM_F1_TSTB: nxt_core.flag = ram_rdata[cur_ff.ir[1:0]]; // RULE5
            `NIM_F1_LDX:  nxt_core.x = cur_ff.ir[1:0];
          endcase
        end
        else if (cur_ff.ir[7:5] != 3'h0)
        begin
          unique case (cur_ff.ir[7:4])
            `NIM_F2_LDYI: nxt_core.y = cur_ff.ir[3:0];
            `NIM_F2_STII:
            begin
              nxt_core.ram.we    = 1'b1;
              nxt_core.ram.wdata = cur_ff.ir[3:0];
              nxt_core.y         = cur_ff.y + 4'h1;
            end
            `NIM_F2_LDPB: nxt_core.pb = cur_ff.ir[3:0];
            `NIM_F2_ALEI: nxt_core.flag = alu_cy; // RULE5
            `NIM_F2_YNEI: nxt_core.flag = (cur_ff.y != cur_ff.ir[3:0]); // RULE6
            default:      nxt_core.flag = 1'b1;
          endcase
        end
        else
        begin
          unique case (cur_ff.ir[4:0])
            `NIM_OP_Y2A:  nxt_core.acc = cur_ff.y; // RULE8
            `NIM_OP_A2Y:  nxt_core.y = cur_ff.acc; // RULE9
            `NIM_OP_CLRA: nxt_core.acc = 4'h0; // RULE10
            `NIM_OP_STA, `NIM_OP_STAI:
            begin
              nxt_core.ram.we    = 1'b1; // RULE11
              nxt_core.ram.wdata = cur_ff.acc; // RULE11
              if (cur_ff.ir[4:0] == `NIM_OP_STAI)
                nxt_core.y = cur_ff.y + 4'h1; // RULE23
            end
            `NIM_OP_M2Y:  nxt_core.y = ram_rdata;
            `NIM_OP_M2A:  nxt_core.acc = ram_rdata;
            `NIM_OP_XCH:
            begin
              nxt_core.acc       = ram_rdata;
              nxt_core.ram.we    = 1'b1;
              nxt_core.ram.wdata = cur_ff.acc;
            end
            `NIM_OP_RET:
            begin
              nxt_core.pc = cur_ff.ret_pc;
              nxt_core.pa = cur_ff.ret_pa;
            end
            `NIM_OP_ADDM, `NIM_OP_INCM:
            begin
              nxt_core.acc  = alu_res; // RULE24
              nxt_core.flag = alu_cy; // RULE3
            end
            `NIM_OP_SUBM, `NIM_OP_DECM, `NIM_OP_DECA:
            begin
              nxt_core.acc  = alu_res; // RULE24
              nxt_core.flag = alu_cy; // RULE4
            end
            `NIM_OP_INCA: nxt_core.acc = alu_res; // RULE24
            `NIM_OP_INCY:
            begin
              nxt_core.y    = alu_res; // RULE24
              nxt_core.flag = alu_cy; // RULE3
            end
            `NIM_OP_DECY:
            begin
              nxt_core.y    = alu_res; // RULE24
              nxt_core.flag = alu_cy; // RULE4
            end
            `NIM_OP_XORM: nxt_core.acc = cur_ff.acc ^ ram_rdata; // RULE24
            `NIM_OP_NEG:
            begin
              nxt_core.acc  = alu_res; // RULE24
              nxt_core.flag = (alu_res == 4'h0); // RULE7
            end
            `NIM_OP_ALEM: nxt_core.flag = alu_cy; // RULE5
            `NIM_OP_MNZ:  nxt_core.flag = (ram_rdata != 4'h0); // RULE6
            `NIM_OP_YNA:  nxt_core.flag = (cur_ff.y != cur_ff.acc); // RULE6
            `NIM_OP_KNZ:  nxt_core.flag = (cur_ff.k_s2 != 4'h0); // RULE6
            `NIM_OP_RNZ:  nxt_core.flag = (cur_ff.r_s2 != 4'h0); // RULE6
            `NIM_OP_RDK:  nxt_core.acc = cur_ff.k_s2; // RULE25
            `NIM_OP_RDR:  nxt_core.acc = cur_ff.r_s2; // RULE25
            `NIM_OP_SETO, `NIM_OP_CLRO:
            begin
              // Target picked by X and Y // RULE15
              if (!cur_ff.x[1])
              begin
                if (cur_ff.y <= `NIM_Y_D_LAST)
                  nxt_core.d_lat[cur_ff.y[2:0]] = out_val; // RULE16
                else if (cur_ff.y == `NIM_Y_CARRIER)
                begin
                  nxt_core.car_run = out_val; // RULE17
                  nxt_core.car_cnt = 4'h0;
                end
                else if (cur_ff.y == `NIM_Y_ALL_D)
                  nxt_core.d_lat = {10{out_val}}; // RULE18
                else if (cur_ff.y <= `NIM_Y_R_LAST)
                  nxt_core.r_lat[cur_ff.y[1:0] - 2'h2] = out_val; // RULE19
                else if (cur_ff.y == `NIM_Y_ALL_R)
                  nxt_core.r_lat = {4{out_val}}; // RULE20
                else
                begin
                  nxt_core.d_lat = {10{out_val}}; // RULE18
                  if (out_val)
                    nxt_core.r_lat = 4'hF; // RULE18
                end
              end
              else if (cur_ff.y == `NIM_Y_D8)
                nxt_core.d_lat[8] = out_val; // RULE21
              else if (cur_ff.y == `NIM_Y_D9)
                nxt_core.d_lat[9] = out_val; // RULE21
            end
            `NIM_OP_WDC:  nxt_core.wdc = 1'b1; // RULE14
            `NIM_OP_HALT: nxt_core.halt = 1'b1;
            `NIM_OP_PMY:  nxt_core.pmode = cur_ff.y[2:0]; // RULE25
            `NIM_OP_NOP:  nxt_core.flag = 1'b1; // RULE25
          endcase
        end
        nxt_core.rom_addr = {nxt_core.pa, nxt_core.pc};
      end
    endcase
    // R pins are open drain: pull low for a zero, release for a one
    nxt_core.r_oe = ~nxt_core.r_lat;
  end

  // Single state register
  always_ff @(posedge mclk)
  begin
    if (srst)
      cur_ff <= CORE_RST;
    else
      cur_ff <= nxt_core;
  end

  assign rom_addr          = cur_ff.rom_addr;
  assign ram_req           = cur_ff.ram;
  assign d_level           = cur_ff.d_lat;
  assign r_out             = cur_ff.r_lat;
  assign r_oe              = cur_ff.r_oe;
  assign carrier_pulse_pin = cur_ff.car_pin;
  assign watchdog_clear    = cur_ff.wdc;
  assign stop_req          = cur_ff.halt;
  assign status_flag       = cur_ff.flag;

  // Checks on the decode and execute behaviour
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  logic ex_f0;
  logic [4:0] add_chk;
  assign ex_f0   = (cur_ff.ph == nim_pkg::PH_EXEC) && (cur_ff.ir[7:5] == 3'h0);
  assign add_chk = {1'b0, cur_ff.acc} + {1'b0, ram_rdata};

  sequence s_instr;
    cur_ff.ph == nim_pkg::PH_FETCH ##1 cur_ff.ph == nim_pkg::PH_DECODE
      ##1 cur_ff.ph == nim_pkg::PH_EXEC ##1 cur_ff.ph == nim_pkg::PH_FETCH;
  endsequence

  chk_phase_order: assert property ( // RULE1
    cur_ff.ph == nim_pkg::PH_FETCH |-> s_instr)
    else $error("phase order broken");
  chk_uncond_flag: assert property ( // RULE2
    ex_f0 && cur_ff.ir[4:0] == `NIM_OP_INCA |=> status_flag)
    else $error("flag not set");
  chk_carry_flag: assert property ( // RULE3
    ex_f0 && cur_ff.ir[4:0] == `NIM_OP_ADDM |=> status_flag == $past(add_chk[4]))
    else $error("carry flag wrong");
  chk_borrow_flag: assert property ( // RULE4
    ex_f0 && cur_ff.ir[4:0] == `NIM_OP_DECA |=> status_flag == ($past(cur_ff.acc) != 4'h0))
    else $error("borrow flag wrong");
  chk_clear_acc: assert property ( // RULE10
    ex_f0 && cur_ff.ir[4:0] == `NIM_OP_CLRA |=> cur_ff.acc == 4'h0)
    else $error("acc not cleared");
  chk_store_acc: assert property ( // RULE11
    ex_f0 && cur_ff.ir[4:0] == `NIM_OP_STA
      |=> ram_req.we && ram_req.wdata == $past(cur_ff.acc) && ram_req.addr == $past(ram_req.addr))
    else $error("store wrong");
  chk_jump_taken: assert property ( // RULE12
    cur_ff.ph == nim_pkg::PH_EXEC && cur_ff.ir[7:6] == 2'h2 && cur_ff.flag
      |=> rom_addr == {$past(cur_ff.pb), $past(cur_ff.ir[5:0])})
    else $error("jump target wrong");
  chk_jump_skip: assert property ( // RULE22
    cur_ff.ph == nim_pkg::PH_EXEC && cur_ff.ir[7:6] == 2'h2 && !cur_ff.flag
      |=> status_flag && rom_addr == $past(seq_addr))
    else $error("skip path wrong");
  chk_wdc_pulse: assert property ( // RULE14
    ex_f0 && cur_ff.ir[4:0] == `NIM_OP_WDC |=> watchdog_clear ##1 !watchdog_clear)
    else $error("watchdog pulse wrong");
  chk_carrier_stop: assert property ( // RULE17
    ex_f0 && cur_ff.ir[4:0] == `NIM_OP_CLRO && !cur_ff.x[1] && cur_ff.y == `NIM_Y_CARRIER
      |=> ##1 !carrier_pulse_pin [*3])
    else $error("carrier not stopped");

endmodule

//--- nim_mem_model.sv
// Program ROM, data RAM and R pin pull-ups facing the nibble core
`timescale 1ns/1ps
module nim_mem_model (
  input  wire logic [0:0]               mclk,
  input  wire logic [9:0]               rom_addr,
  input  wire nim_pkg::nim_ram_req_type ram_req,
  input  wire logic [3:0]               r_oe,
  output logic      [7:0]               rom_data,
  output logic      [3:0]               ram_rdata,
  output logic      [3:0]               r_in
);
  logic [7:0] rom [1024];
  logic [3:0] ram [32];

  // Unwritten code reads as no-op, so a runaway core only drifts forward
  initial
  begin
    foreach (rom[i]) rom[i] = 8'h1F;
    foreach (ram[i]) ram[i] = 4'h0;
  end

  // Synchronous memories: address taken at an edge, data one cycle later
  always @(posedge mclk)
  begin
    rom_data <= rom[rom_addr];
    ram_rdata <= ram[ram_req.addr];
    if (ram_req.we)
      ram[ram_req.addr] <= ram_req.wdata;
  end

  // Pull-up on R pins: a pin reads low only where the core sinks it
  assign r_in = ~r_oe;
endmodule

//--- nim_params.svh
// Constants of the nibble core: opcode codes, reset values, output selects, carrier timing
`ifndef NIM_PARAMS_SVH
`define NIM_PARAMS_SVH

// Single-opcode group, selected by ir[4:0] while ir[7:5] is zero
`define NIM_OP_Y2A    5'h00
`define NIM_OP_A2Y    5'h01
`define NIM_OP_CLRA   5'h02
`define NIM_OP_STA    5'h03
`define NIM_OP_STAI   5'h04
`define NIM_OP_M2Y    5'h05
`define NIM_OP_M2A    5'h06
`define NIM_OP_XCH    5'h07
`define NIM_OP_RET    5'h08
`define NIM_OP_ADDM   5'h09
`define NIM_OP_SUBM   5'h0A
`define NIM_OP_INCM   5'h0B
`define NIM_OP_DECM   5'h0C
`define NIM_OP_INCA   5'h0D
`define NIM_OP_INCY   5'h0E
`define NIM_OP_DECA   5'h0F
`define NIM_OP_DECY   5'h10
`define NIM_OP_XORM   5'h11
`define NIM_OP_NEG    5'h12
`define NIM_OP_ALEM   5'h13
`define NIM_OP_MNZ    5'h14
`define NIM_OP_YNA    5'h15
`define NIM_OP_KNZ    5'h16
`define NIM_OP_RNZ    5'h17
`define NIM_OP_RDK    5'h18
`define NIM_OP_RDR    5'h19
`define NIM_OP_SETO   5'h1A
`define NIM_OP_CLRO   5'h1B
`define NIM_OP_WDC    5'h1C
`define NIM_OP_HALT   5'h1D
`define NIM_OP_PMY    5'h1E
`define NIM_OP_NOP    5'h1F

// Four-bit operand group, selected by ir[7:4]
`define NIM_F2_LDYI   4'h2
`define NIM_F2_STII   4'h3
`define NIM_F2_LDPB   4'h4
`define NIM_F2_ALEI   4'h5
`define NIM_F2_YNEI   4'h6
// Two-bit operand group: ir[7:4] fixed, ir[3:2] selects, ir[1:0] operand
`define NIM_F1_NIB    4'h7
`define NIM_F1_SETB   2'h0
`define NIM_F1_CLRB   2'h1
`define NIM_F1_TSTB   2'h2
`define NIM_F1_LDX    2'h3
// Six-bit address group: ir[6] is high for the call form
`define NIM_F3_CALL   1'h1

// Reset values
`define NIM_RST_PMODE 3'h0
`define NIM_RST_FLAG  1'h1
`define NIM_RST_R     4'hF

// Output selects carried in Y
`define NIM_Y_D_LAST  4'h7
`define NIM_Y_CARRIER 4'h8
`define NIM_Y_ALL_D   4'h9
`define NIM_Y_R_FIRST 4'hA
`define NIM_Y_R_LAST  4'hD
`define NIM_Y_ALL_R   4'hE
`define NIM_Y_ALL_DR  4'hF
`define NIM_Y_D8      4'h0
`define NIM_Y_D9      4'h1

// Carrier modes, period and high time in clock cycles
`define NIM_MODE_FIXED 3'h5
`define NIM_PER_12    4'hC
`define NIM_PER_8     4'h8
`define NIM_PER_11    4'hB
`define NIM_HI_6      4'h6
`define NIM_HI_4      4'h4
`define NIM_HI_3      4'h3
`define NIM_HI_2      4'h2

`endif

//--- nim_pkg.sv
// Types shared by the nibble core: phases, RAM request and the core state record
package nim_pkg;

  typedef enum logic [2:0] {
    PH_FETCH  = 3'h1,
    PH_DECODE = 3'h2,
    PH_EXEC   = 3'h4
  } nim_phase_type;

  typedef struct packed {
    logic       we;
    logic [4:0] addr;
    logic [3:0] wdata;
  } nim_ram_req_type;

  typedef struct packed {
    nim_phase_type   ph;
    logic [7:0]      ir;
    logic [5:0]      pc;
    logic [3:0]      pa;
    logic [3:0]      pb;
    logic [5:0]      ret_pc;
    logic [3:0]      ret_pa;
    logic [3:0]      acc;
    logic [3:0]      y;
    logic [1:0]      x;
    logic            flag;
    logic [2:0]      pmode;
    logic [9:0]      rom_addr;
    nim_ram_req_type ram;
    logic [9:0]      d_lat;
    logic [3:0]      r_lat;
    logic [3:0]      r_oe;
    logic            car_run;
    logic [3:0]      car_cnt;
    logic            car_pin;
    logic            wdc;
    logic            halt;
    logic [3:0]      k_s1;
    logic [3:0]      k_s2;
    logic [3:0]      r_s1;
    logic [3:0]      r_s2;
  } nim_core_type;

endpackage

//--- tb_top.sv
// Self-checking bench for the nibble core, running instruction sequences
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin \
    checked++; \
    if ((g) !== (e)) \
    begin \
      miscompares++; \
      $display("unexpected %s: expected %h, seen %h", nm, e, g); \
    end \
  end
module tb_top;
  logic                     mclk = 1'b0;
  logic                     srst = 1'b1;
  logic [3:0]               k_pins = 4'h0;
  logic [7:0]               rom_data;
  logic [3:0]               ram_rdata;
  logic [3:0]               r_in;
  logic [9:0]               rom_addr;
  nim_pkg::nim_ram_req_type ram_req;
  logic [9:0]               d_level;
  logic [3:0]               r_out;
  logic [3:0]               r_oe;
  logic                     carrier_pulse_pin;
  logic                     watchdog_clear;
  logic                     stop_req;
  logic                     status_flag;
  logic                     last;
  int                       checked = 0;
  int                       miscompares = 0;
  int                       rises;

  always #2 mclk = ~mclk;

  nim_core i_nim_core (.mclk(mclk), .srst(srst), .rom_data(rom_data), .ram_rdata(ram_rdata),
    .k_pins(k_pins), .r_in(r_in), .rom_addr(rom_addr), .ram_req(ram_req), .d_level(d_level),
    .r_out(r_out), .r_oe(r_oe), .carrier_pulse_pin(carrier_pulse_pin),
    .watchdog_clear(watchdog_clear), .stop_req(stop_req), .status_flag(status_flag));
  nim_mem_model i_nim_mem_model (.mclk(mclk), .rom_addr(rom_addr), .ram_req(ram_req),
    .r_oe(r_oe), .rom_data(rom_data), .ram_rdata(ram_rdata), .r_in(r_in));

  task automatic stop_test;
  begin
    $display("checked %0d, miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  end
  endtask

  // Present one byte for the address being fetched, then look after its execute
  task automatic ex(input logic [7:0] op, input logic f);
  begin
    i_nim_mem_model.rom[rom_addr] = op;
    repeat (3) @(posedge mclk);
    #1;
    `CHK("status_flag", f, status_flag)
  end
  endtask

  // Hang guard: the whole program needs a few hundred cycles
  initial
  begin
    repeat (3000) @(posedge mclk);
    miscompares++;
    stop_test();
  end

  initial
  begin
    repeat (12) @(posedge mclk);
    #1;
    `CHK("d_level", 10'h000, d_level)
    `CHK("r_out", 4'hF, r_out)
    srst = 1'b0;
    // Arithmetic and flag classes, accumulator seen through stores
    ex(8'h25, 1'b1);
    ex(8'h00, 1'b1);
    ex(8'h03, 1'b1);
    `CHK("we", 1'b1, ram_req.we)
    `CHK("wdata", 4'h5, ram_req.wdata)
    `CHK("addr", 5'h05, ram_req.addr)
    ex(8'h09, 1'b0);
    ex(8'h03, 1'b1);
    `CHK("wdata", 4'hA, ram_req.wdata)
    ex(8'h09, 1'b1);
    ex(8'h0F, 1'b1);
    ex(8'h0A, 1'b1);
    ex(8'h12, 1'b0);
    ex(8'h02, 1'b1);
    ex(8'h12, 1'b1);
    ex(8'h0F, 1'b0);
    ex(8'h11, 1'b1);
    ex(8'h03, 1'b1);
    `CHK("wdata", 4'h5, ram_req.wdata)
    $display("test arithmetic done");
    // Branch not taken, taken, call and return
    ex(8'h65, 1'b0);
    ex(8'hA0, 1'b1);
    `CHK("rom_addr", 10'h010, rom_addr)
    ex(8'h44, 1'b1);
    ex(8'h90, 1'b1);
    `CHK("rom_addr", 10'h110, rom_addr)
    ex(8'hC8, 1'b1);
    `CHK("rom_addr", 10'h108, rom_addr)
    ex(8'h08, 1'b1);
    `CHK("rom_addr", 10'h111, rom_addr)
    ex(8'h16, 1'b0);
    ex(8'h13, 1'b1);
    ex(8'h79, 1'b0);
    ex(8'h78, 1'b1);
    $display("test branch done");
    // Output selection by X and Y; R cleared first so the Y=F set is visible
    ex(8'h01, 1'b1);
    ex(8'h1A, 1'b1);
    `CHK("d_level", 10'h020, d_level)
    ex(8'h2E, 1'b1);
    ex(8'h1B, 1'b1);
    `CHK("r_out", 4'h0, r_out)
    `CHK("r_oe", 4'hF, r_oe)
    ex(8'h2B, 1'b1);
    ex(8'h1A, 1'b1);
    `CHK("r_out", 4'h2, r_out)
    ex(8'h2F, 1'b1);
    ex(8'h1A, 1'b1);
    `CHK("d_level", 10'h3FF, d_level)
    `CHK("r_out", 4'hF, r_out)
    `CHK("r_oe", 4'h0, r_oe)
    ex(8'h29, 1'b1);
    ex(8'h1B, 1'b1);
    `CHK("d_level", 10'h000, d_level)
    ex(8'h7F, 1'b1);
    ex(8'h21, 1'b1);
    ex(8'h1A, 1'b1);
    `CHK("d_level", 10'h200, d_level)
    ex(8'h1C, 1'b1);
    `CHK("watchdog_clear", 1'b1, watchdog_clear)
    ex(8'h1D, 1'b1);
    `CHK("stop_req", 1'b1, stop_req)
    ex(8'h1F, 1'b1);
    `CHK("watchdog_clear", 1'b0, watchdog_clear)
    ex(8'h04, 1'b1);
    `CHK("addr", 5'h11, ram_req.addr)
    ex(8'h03, 1'b1);
    `CHK("addr", 5'h12, ram_req.addr)
    $display("test outputs done");
    // Carrier in mode 0 toggles, then stops low
    ex(8'h7C, 1'b1);
    ex(8'h28, 1'b1);
    ex(8'h1A, 1'b1);
    rises = 0;
    last = carrier_pulse_pin;
    repeat (30)
    begin
      @(posedge mclk);
      #1;
      if (carrier_pulse_pin === 1'b1 && last === 1'b0)
        rises++;
      last = carrier_pulse_pin;
    end
    `CHK("carrier rises", 3, rises)
    ex(8'h1B, 1'b1);
    ex(8'h1F, 1'b1);
    `CHK("carrier", 1'b0, carrier_pulse_pin)
    // Mode 5 gives a steady high level instead of pulses
    ex(8'h25, 1'b1);
    ex(8'h1E, 1'b1);
    ex(8'h28, 1'b1);
    ex(8'h1A, 1'b1);
    ex(8'h1F, 1'b1);
    `CHK("carrier fixed", 1'b1, carrier_pulse_pin)
    $display("test carrier done");
    // Y pointer step flags, then K and R pins read through the accumulator
    ex(8'h10, 1'b1);
    ex(8'h0E, 1'b0);
    k_pins = 4'h6;
    ex(8'h16, 1'b1);
    ex(8'h18, 1'b1);
    ex(8'h03, 1'b1);
    `CHK("wdata", 4'h6, ram_req.wdata)
    `CHK("addr", 5'h08, ram_req.addr)
    ex(8'h17, 1'b1);
    ex(8'h19, 1'b1);
    ex(8'h03, 1'b1);
    `CHK("wdata", 4'hF, ram_req.wdata)
    $display("test inputs done");
    stop_test();
  end
endmodule
